// ### motor_startup_config_reg.sv
// apb register holding the open-loop start-up configuration, with decoded outputs for the sequencer
//
// Our own choice: register access over APB.
`timescale 1ns/1ps
module motor_startup_config_reg
    import startup_cfg_pkg::*;
#(
    parameter int ADDR_W = 12                     // apb byte address width
) (
    input wire logic pclk,                        // 10 MHz system clock
    input wire logic presetn,                     // async reset, active low
    input wire logic psel,                        // apb select
    input wire logic penable,                     // apb access phase
    input wire logic pwrite,                      // apb direction, high writes
    input wire logic [ADDR_W-1:0] paddr,          // apb byte address
    input wire logic [31:0] pwdata,               // apb write data
    output logic [31:0] prdata,                   // apb read data, registered
    output logic pready,                          // apb ready, always high
    output logic pslverr,                         // apb error on unmapped access
    output cfg_fields_t cfg_fields,               // raw fields, registered
    output startup_decoded_t cfg_decoded          // decoded values, registered
);

    // ----------------------------------------------------------------
    // address decode
    // ----------------------------------------------------------------
    localparam logic [ADDR_W-1:0] CFG_ADDR = ADDR_W'({CFG_TWO_INDEX, 2'b00});   // index times four
    localparam logic [ADDR_W-1:0] STATUS_ADDR = ADDR_W'({STATUS_INDEX, 2'b00});

    logic hit_cfg;        // address selects the configuration word
    logic hit_status;     // address selects the status word
    logic setup_phase;    // first cycle of a transfer
    logic access_phase;   // cycle in which the transfer completes
    logic [31:0] cfg;     // the register itself
    logic [31:0] status;  // block status word

    assign hit_cfg = (paddr == CFG_ADDR);
    assign hit_status = (paddr == STATUS_ADDR);
    assign setup_phase = psel && !penable;
    assign access_phase = psel && penable;

    // zero wait states keep the sequencer's view one cycle behind software at most
    assign pready = 1'b1;
    // writes to status and unknown addresses both report an error
    assign pslverr = access_phase && !(hit_cfg || (hit_status && !pwrite));

    // ----------------------------------------------------------------
    // configuration storage
    // ----------------------------------------------------------------
    // every bit, spare bit 31 included, takes the written value
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg <= CFG_TWO_RESET;
        end else if (access_phase && pwrite && hit_cfg) begin
            cfg <= pwdata;
        end
    end

    assign cfg_fields = cfg_fields_t'(cfg);

    // ----------------------------------------------------------------
    // read data
    // ----------------------------------------------------------------
    // sampled in the setup cycle so it is a flip-flop output during access
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= UNMAPPED_READ;
        end else if (setup_phase && !pwrite) begin
            if (hit_cfg) begin
                prdata <= cfg;
            end else if (hit_status) begin
                prdata <= status;
            end else begin
                prdata <= UNMAPPED_READ;
            end
        end
    end

    // ----------------------------------------------------------------
    // decoded view for the start-up sequencer
    // ----------------------------------------------------------------
    // decode is registered to keep the big tables off the bus timing path
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_decoded <= '0;
        end else begin
            cfg_decoded.current_cap_ma <= cap_ma(cfg[CAP_LSB +: 4]);
            cfg_decoded.accel_linear_chz <= accel_ladder(cfg[ACC_LIN_LSB +: 4]);
            // code zero means no quadratic term at all
            if (cfg[ACC_QUAD_LSB +: 4] == 4'h0) begin
                cfg_decoded.accel_quad_chz <= 20'd0;
            end else begin
                cfg_decoded.accel_quad_chz <= accel_ladder(cfg[ACC_QUAD_LSB +: 4]);
            end
            cfg_decoded.use_fixed_handoff <= !cfg[AUTO_BIT];
            cfg_decoded.handoff_pct_tenths <= xfer_tenths(cfg[XFER_LSB +: 5]);
            cfg_decoded.align_deg <= align_table(cfg[ALIGN_LSB +: 5]);
            cfg_decoded.align_reserved <= (cfg[ALIGN_LSB +: 5] >= ALIGN_FIRST_RESERVED);
            // zero hertz first cycle unless the programmed speed is chosen
            if (cfg[INIT_SEL_BIT]) begin
                cfg_decoded.first_cycle_tenths <= first_tenths(cfg[INIT_PCT_LSB +: 4]);
            end else begin
                cfg_decoded.first_cycle_tenths <= 10'd0;
            end
            cfg_decoded.ramp_cdeg_ms <= ramp_table(cfg[RAMP_LSB +: 3]);
        end
    end

    // ----------------------------------------------------------------
    // status word
    // ----------------------------------------------------------------
    // bit 0 reserved align code, bit 1 fixed handoff in use; follows the decode
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status <= STATUS_RESET;
        end else begin
            status <= {30'h00000000, !cfg[AUTO_BIT], (cfg[ALIGN_LSB +: 5] >= ALIGN_FIRST_RESERVED)};
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    a_write_store: assert property (
        @(posedge pclk) disable iff (!presetn)
        (access_phase && pwrite && hit_cfg) |=> (cfg == $past(pwdata)))
        else $error("config write not stored");

    a_read_back: assert property (
        @(posedge pclk) disable iff (!presetn)
        (access_phase && !pwrite && hit_cfg && $past(setup_phase)) |-> (prdata == cfg))
        else $error("config read data wrong");

    a_cap_decode: assert property (
        @(posedge pclk) disable iff (!presetn)
        (cfg[CAP_LSB +: 4] == 4'hD) |=> (cfg_decoded.current_cap_ma == 14'd6000))
        else $error("current cap code 13 not 6.0 A");

    a_accel_linear: assert property (
        @(posedge pclk) disable iff (!presetn)
        (cfg[ACC_LIN_LSB +: 4] == 4'h0) |=> (cfg_decoded.accel_linear_chz == 20'd1))
        else $error("linear accel code 0 not 0.01 Hz/s");

    a_accel_quad: assert property (
        @(posedge pclk) disable iff (!presetn)
        (cfg[ACC_QUAD_LSB +: 4] == 4'h0) |=> (cfg_decoded.accel_quad_chz == 20'd0))
        else $error("quadratic accel code 0 not zero");

    a_handoff_mode: assert property (
        @(posedge pclk) disable iff (!presetn)
        $rose(cfg[AUTO_BIT]) |=> (!cfg_decoded.use_fixed_handoff && status[1] == 1'b0))
        else $error("auto handoff not honoured");

    a_handoff_pct: assert property (
        @(posedge pclk) disable iff (!presetn)
        (cfg[XFER_LSB +: 5] == 5'h14) |=> (cfg_decoded.handoff_pct_tenths == 10'd225))
        else $error("handoff code 14h not 22.5 percent");

    a_align_reserved: assert property (
        @(posedge pclk) disable iff (!presetn)
        (cfg[ALIGN_LSB +: 5] == 5'h1C) |=> (!cfg_decoded.align_reserved && cfg_decoded.align_deg == 9'd350))
        else $error("align code 1Ch not 350 deg");

    a_first_choice: assert property (
        @(posedge pclk) disable iff (!presetn)
        (!cfg[INIT_SEL_BIT]) |=> (cfg_decoded.first_cycle_tenths == 10'd0))
        else $error("first cycle speed not zero when unselected");

    a_ramp_top: assert property (
        @(posedge pclk) disable iff (!presetn)
        (cfg[RAMP_LSB +: 3] == 3'h7) |=> (cfg_decoded.ramp_cdeg_ms == 8'd200))
        else $error("ramp code 7 not 2 deg/ms");

    a_spare_store: assert property (
        @(posedge pclk) disable iff (!presetn)
        (access_phase && pwrite && hit_cfg) |=> (cfg_fields.spare == $past(pwdata[31])))
        else $error("spare bit not stored");

    // a change of the spare bit alone must leave the sequencer's view untouched
    a_spare_inert: assert property (
        @(posedge pclk) disable iff (!presetn)
        ($changed(cfg[31]) && $stable(cfg[30:0])) |=> ($stable(cfg_decoded) && $stable(status)))
        else $error("spare bit changed the decode");

    a_cap_low: assert property (
        @(posedge pclk) disable iff (!presetn)
        (cfg[CAP_LSB +: 4] == 4'h0) |=> (cfg_decoded.current_cap_ma == 14'd125))
        else $error("current cap code 0 not 0.125 A");

    a_cap_top: assert property (
        @(posedge pclk) disable iff (!presetn)
        (cfg[CAP_LSB +: 4] == 4'hF) |=> (cfg_decoded.current_cap_ma == 14'd8000))
        else $error("current cap code 15 not 8.0 A");

    a_handoff_low: assert property (
        @(posedge pclk) disable iff (!presetn)
        (cfg[XFER_LSB +: 5] == 5'h00) |=> (cfg_decoded.handoff_pct_tenths == 10'd10))
        else $error("handoff code 0 not 1 percent");

    a_align_resv_code: assert property (
        @(posedge pclk) disable iff (!presetn)
        (cfg[ALIGN_LSB +: 5] >= ALIGN_FIRST_RESERVED) |=> (cfg_decoded.align_reserved && cfg_decoded.align_deg == 9'd0))
        else $error("reserved align code not flagged");

    a_first_speed: assert property (
        @(posedge pclk) disable iff (!presetn)
        (cfg[INIT_SEL_BIT] && cfg[INIT_PCT_LSB +: 4] == 4'h0) |=> (cfg_decoded.first_cycle_tenths == 10'd10))
        else $error("first cycle code 0 not 1 percent");

    // refused writes flag an error and leave the stored word alone
    a_write_refused: assert property (
        @(posedge pclk) disable iff (!presetn)
        (access_phase && pwrite && !hit_cfg) |-> (pslverr ##1 $stable(cfg)))
        else $error("refused write not flagged or stored");

    a_read_unmapped: assert property (
        @(posedge pclk) disable iff (!presetn)
        (access_phase && !pwrite && !hit_cfg && !hit_status && $past(setup_phase)) |-> (prdata == UNMAPPED_READ))
        else $error("unmapped read data not zero");

endmodule

// ### startup_cfg_pkg.sv
// constants, field layout, decode tables and carriers for the start-up configuration register
package startup_cfg_pkg;

    // ----------------------------------------------------------------
    // register map
    // ----------------------------------------------------------------
    localparam logic [11:0] CFG_TWO_INDEX = 12'h086;            // printed offset, word index
    localparam logic [11:0] STATUS_INDEX = 12'h087;             // block status word, index
    localparam logic [31:0] CFG_TWO_RESET = 32'h00000000;       // whole register clears at reset
    localparam logic [31:0] STATUS_RESET = 32'h00000000;
    localparam logic [31:0] UNMAPPED_READ = 32'h00000000;       // read data on an unmapped address

    // ----------------------------------------------------------------
    // field positions
    // ----------------------------------------------------------------
    localparam int CAP_LSB = 27;          // current cap, 4 bits
    localparam int ACC_LIN_LSB = 23;      // linear accel, 4 bits
    localparam int ACC_QUAD_LSB = 19;     // quadratic accel, 4 bits
    localparam int AUTO_BIT = 18;         // automatic handoff enable
    localparam int XFER_LSB = 13;         // handoff threshold, 5 bits
    localparam int ALIGN_LSB = 8;         // align angle, 5 bits
    localparam int INIT_PCT_LSB = 4;      // first cycle speed, 4 bits
    localparam int INIT_SEL_BIT = 3;      // first cycle speed choice
    localparam int RAMP_LSB = 0;          // theta error ramp, 3 bits
    localparam logic [4:0] ALIGN_FIRST_RESERVED = 5'h1D;

    // ----------------------------------------------------------------
    // carriers
    // ----------------------------------------------------------------
    typedef struct packed {
        logic spare;                               // bit 31, stored only
        logic [3:0] open_loop_current_cap;
        logic [3:0] open_loop_accel_linear;
        logic [3:0] open_loop_accel_quadratic;
        logic auto_handoff;
        logic [4:0] loop_transfer_speed_pct;
        logic [4:0] align_angle;
        logic [3:0] initial_cycle_speed_pct;
        logic initial_cycle_speed_choice;
        logic [2:0] theta_ramp;
    } cfg_fields_t;

    typedef struct packed {
        logic [13:0] current_cap_ma;       // milliamps
        logic [19:0] accel_linear_chz;     // 0.01 Hz/s units
        logic [19:0] accel_quad_chz;       // 0.01 Hz/s^2 units
        logic use_fixed_handoff;           // high when the threshold applies
        logic [9:0] handoff_pct_tenths;    // 0.1 % of max speed
        logic [8:0] align_deg;             // degrees, zero for reserved codes
        logic align_reserved;              // reserved align code programmed
        logic [9:0] first_cycle_tenths;    // 0.1 % of max speed, zero if 0 Hz chosen
        logic [7:0] ramp_cdeg_ms;          // 0.01 deg/ms units
    } startup_decoded_t;

    // ----------------------------------------------------------------
    // decode tables
    // ----------------------------------------------------------------
    function automatic logic [13:0] cap_ma(input logic [3:0] c);
        unique case (c)
            4'h0: cap_ma = 14'd125;
            4'h1: cap_ma = 14'd250;
            4'h2: cap_ma = 14'd500;
            4'hE: cap_ma = 14'd7000;
            4'hF: cap_ma = 14'd8000;
            default: cap_ma = 14'(1000 + 500 * (int'(c) - 3)); // 1.0 A to 6.0 A
        endcase
    endfunction

    // shared ladder of both acceleration coefficients, codes 0..15
    function automatic logic [19:0] accel_ladder(input logic [3:0] c);
        unique case (c)
            4'h0: accel_ladder = 20'd1;
            4'h1: accel_ladder = 20'd5;
            4'h2: accel_ladder = 20'd100;
            4'h3: accel_ladder = 20'd250;
            4'h4: accel_ladder = 20'd500;
            4'h5: accel_ladder = 20'd1000;
            4'h6: accel_ladder = 20'd2500;
            4'h7: accel_ladder = 20'd5000;
            4'h8: accel_ladder = 20'd7500;
            4'h9: accel_ladder = 20'd10000;
            4'hA: accel_ladder = 20'd25000;
            4'hB: accel_ladder = 20'd50000;
            4'hC: accel_ladder = 20'd75000;
            4'hD: accel_ladder = 20'd100000;
            4'hE: accel_ladder = 20'd500000;
            4'hF: accel_ladder = 20'd1000000;
        endcase
    endfunction

    function automatic logic [9:0] xfer_tenths(input logic [4:0] c);
        if (c <= 5'h13) begin
            xfer_tenths = 10'((int'(c) + 1) * 10);        // 1 % steps
        end else begin
            xfer_tenths = 10'(200 + 25 * (int'(c) - 19)); // 2.5 % steps
        end
    endfunction

    function automatic logic [8:0] align_table(input logic [4:0] c);
        unique case (c)
            5'h00: align_table = 9'd0;
            5'h01: align_table = 9'd10;
            5'h02: align_table = 9'd20;
            5'h03: align_table = 9'd30;
            5'h04: align_table = 9'd45;
            5'h05: align_table = 9'd60;
            5'h06: align_table = 9'd70;
            5'h07: align_table = 9'd80;
            5'h08: align_table = 9'd90;
            5'h09: align_table = 9'd110;
            5'h0A: align_table = 9'd120;
            5'h0B: align_table = 9'd135;
            5'h0C: align_table = 9'd150;
            5'h0D: align_table = 9'd160;
            5'h0E: align_table = 9'd170;
            5'h0F: align_table = 9'd180;
            5'h10: align_table = 9'd190;
            5'h11: align_table = 9'd210;
            5'h12: align_table = 9'd225;
            5'h13: align_table = 9'd240;
            5'h14: align_table = 9'd250;
            5'h15: align_table = 9'd260;
            5'h16: align_table = 9'd270;
            5'h17: align_table = 9'd280;
            5'h18: align_table = 9'd290;
            5'h19: align_table = 9'd300;
            5'h1A: align_table = 9'd315;
            5'h1B: align_table = 9'd340;
            5'h1C: align_table = 9'd350;
            default: align_table = 9'd0;  // reserved codes
        endcase
    endfunction

    function automatic logic [9:0] first_tenths(input logic [3:0] c);
        unique case (c)
            4'h0: first_tenths = 10'd10;
            4'h1: first_tenths = 10'd20;
            4'h2: first_tenths = 10'd30;
            4'h3: first_tenths = 10'd50;
            4'h4: first_tenths = 10'd75;
            4'h5: first_tenths = 10'd100;
            4'h6: first_tenths = 10'd125;
            4'h7: first_tenths = 10'd150;
            4'h8: first_tenths = 10'd175;
            4'h9: first_tenths = 10'd200;
            4'hA: first_tenths = 10'd250;
            4'hB: first_tenths = 10'd300;
            4'hC: first_tenths = 10'd350;
            4'hD: first_tenths = 10'd400;
            4'hE: first_tenths = 10'd450;
            4'hF: first_tenths = 10'd500;
        endcase
    endfunction

    function automatic logic [7:0] ramp_table(input logic [2:0] c);
        unique case (c)
            3'h0: ramp_table = 8'd1;
            3'h1: ramp_table = 8'd5;
            3'h2: ramp_table = 8'd10;
            3'h3: ramp_table = 8'd15;
            3'h4: ramp_table = 8'd20;
            3'h5: ramp_table = 8'd50;
            3'h6: ramp_table = 8'd100;
            3'h7: ramp_table = 8'd200;
        endcase
    endfunction

endpackage

// ### tb_top.sv
// self-checking bench for the start-up configuration register
`timescale 1ns/1ps
module tb_top
    import startup_cfg_pkg::*;
;
    // ------------------------------------------------------------
    // signals and expected-value tables
    // ------------------------------------------------------------
    localparam logic [11:0] CFG_ADDR = {CFG_TWO_INDEX[9:0], 2'b00};  // word index to byte address
    localparam logic [11:0] STAT_ADDR = {STATUS_INDEX[9:0], 2'b00};
    logic pclk = 1'b0;                  // 10 MHz
    logic presetn;                      // active low
    logic psel, penable, pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic pready, pslverr;
    cfg_fields_t cfg_fields;
    startup_decoded_t cfg_decoded;
    int bad_count = 0;
    int samples_checked = 0;
    // acceleration ladder in 0.01 Hz/s units
    logic [19:0] acc_tab [16] = '{20'h1, 20'h5, 20'h64, 20'hFA, 20'h1F4, 20'h3E8, 20'h9C4, 20'h1388,
        20'h1D4C, 20'h2710, 20'h61A8, 20'hC350, 20'h124F8, 20'h186A0, 20'h7A120, 20'hF4240};
    // align angle in degrees, reserved codes read as zero
    logic [8:0] ang_tab [32] = '{9'h0, 9'hA, 9'h14, 9'h1E, 9'h2D, 9'h3C, 9'h46, 9'h50, 9'h5A, 9'h6E, 9'h78,
        9'h87, 9'h96, 9'hA0, 9'hAA, 9'hB4, 9'hBE, 9'hD2, 9'hE1, 9'hF0, 9'hFA, 9'h104, 9'h10E, 9'h118, 9'h122,
        9'h12C, 9'h13B, 9'h154, 9'h15E, 9'h0, 9'h0, 9'h0};
    // first cycle speed in 0.1 % units
    logic [9:0] fst_tab [16] = '{10'hA, 10'h14, 10'h1E, 10'h32, 10'h4B, 10'h64, 10'h7D, 10'h96, 10'hAF,
        10'hC8, 10'hFA, 10'h12C, 10'h15E, 10'h190, 10'h1C2, 10'h1F4};
    logic [7:0] rmp_tab [8] = '{8'h1, 8'h5, 8'hA, 8'hF, 8'h14, 8'h32, 8'h64, 8'hC8};  // 0.01 deg/ms

    always #50 pclk = ~pclk;  // half of the 100 ns period

    motor_startup_config_reg dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .cfg_fields(cfg_fields), .cfg_decoded(cfg_decoded));

    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic conclude();
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        samples_checked++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    // one apb transfer, entered just after a rising edge; releases only after pready is seen
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] rd, output logic err);
        int n;
        n = 0;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1 && n < 16) begin
            n++;
            @(posedge pclk);
        end
        if (n == 16) begin  // a hung slave ends the run
            bad_count++;
            $display("BAD %0t no ready", $time);
            conclude();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    // decode of an all-zero register, seen one cycle after reset release
    task automatic zero_state(input logic [31:0] fields);
        chk(cfg_fields, fields, "fields");
        chk(cfg_decoded.current_cap_ma, 32'h7D, "cap");
        chk(cfg_decoded.accel_linear_chz, 32'h1, "lin");
        chk(cfg_decoded.accel_quad_chz, 32'h0, "quad");
        chk(cfg_decoded.use_fixed_handoff, 32'h1, "fixed");
        chk(cfg_decoded.first_cycle_tenths, 32'h0, "first");
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    // every code of every field, each field but cap and handoff (both fed k) fed a different code so swapped fields show
    task automatic sweep();
        logic [31:0] w, rd;
        logic err;
        logic [3:0] cap, lin, quad, pct;
        logic [4:0] xf, al;
        logic [2:0] rp;
        for (int k = 0; k < 32; k++) begin
            cap = 4'(k);
            lin = 4'(k + 3);
            quad = 4'(k + 7);
            xf = 5'(k);
            al = 5'(31 - k);
            pct = 4'(k + 1);
            rp = 3'(k + 2);
            w = {k[2], cap, lin, quad, k[1], xf, al, pct, k[0], rp};
            apb(1'b1, CFG_ADDR, w, rd, err);
            #1;
            chk(err, 32'h0, "write err");
            chk(cfg_fields, w, "fields");
            chk(cfg_decoded.current_cap_ma, (cap < 4'h3) ? (32'h7D << cap) :
                (cap > 4'hD) ? 32'h1B58 + 32'h3E8 * (cap - 4'hE) : 32'h3E8 + 32'h1F4 * (cap - 4'h3), "cap");
            chk(cfg_decoded.accel_linear_chz, acc_tab[lin], "lin");
            chk(cfg_decoded.accel_quad_chz, (quad == 4'h0) ? 32'h0 : acc_tab[quad], "quad");
            chk(cfg_decoded.use_fixed_handoff, !k[1], "fixed");
            chk(cfg_decoded.handoff_pct_tenths, (xf <= 5'h13) ? 32'hA * (xf + 1) :
                32'hC8 + 32'h19 * (xf - 5'h13), "pct");
            chk(cfg_decoded.align_deg, ang_tab[al], "align");
            chk(cfg_decoded.align_reserved, al >= 5'h1D, "resv");
            chk(cfg_decoded.first_cycle_tenths, k[0] ? fst_tab[pct] : 10'h0, "first");
            chk(cfg_decoded.ramp_cdeg_ms, rmp_tab[rp], "ramp");
            @(posedge pclk);
            apb(1'b0, STAT_ADDR, 32'h0, rd, err);
            chk(rd, {30'h0, !k[1], al >= 5'h1D}, "status");
            apb(1'b0, CFG_ADDR, 32'h0, rd, err);
            chk(err, 32'h0, "readback err");
            chk(rd, w, "readback");
        end
    endtask

    // refused accesses leave the register alone
    task automatic refusals();
        logic [31:0] rd, keep;
        logic err;
        logic [11:0] bad_addr [3] = '{STAT_ADDR, CFG_ADDR - 12'h4, 12'h100};
        keep = cfg_fields;
        for (int i = 0; i < 3; i++) begin
            apb(1'b1, bad_addr[i], 32'hA5A5A5A5, rd, err);
            chk(err, 32'h1, "write refused");
        end
        apb(1'b0, 12'h100, 32'h0, rd, err);
        chk(err, 32'h1, "unmapped read err");
        chk(rd, 32'h0, "unmapped read");
        apb(1'b0, CFG_ADDR, 32'h0, rd, err);
        chk(rd, keep, "kept");
    endtask

    // reset in mid-run clears everything
    task automatic mid_reset();
        logic [31:0] rd;
        logic err;
        apb(1'b1, CFG_ADDR, 32'hFFFFFFFF, rd, err);
        presetn <= 1'b0;
        #1;
        chk(cfg_fields, 32'h0, "async clear");
        @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        #1;
        zero_state(32'h0);
        @(posedge pclk);
        apb(1'b0, CFG_ADDR, 32'h0, rd, err);
        chk(rd, CFG_TWO_RESET, "reset read");
        // the spare bit alone is stored but must not move any decoded value
        apb(1'b1, CFG_ADDR, 32'h80000000, rd, err);
        #1;
        zero_state(32'h80000000);
    endtask

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h0;
        pwdata = 32'h0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        #1;
        zero_state(32'h0);
        @(posedge pclk);
        sweep();
        refusals();
        mid_reset();
        conclude();
    end
endmodule
